/* File: include/adcrb_pkg.sv */
// Constants, field layouts and types of the converter control register bank
package adcrb_pkg;
    // Register width and byte addresses
    localparam int REG_W = 8;
    localparam logic [7:0] OFS_OPSTATE = 8'h00;
    localparam logic [7:0] OFS_IFGEN = 8'h02;
    localparam logic [7:0] OFS_CFG_LOW = 8'h06;
    localparam logic [7:0] OFS_CFG_HIGH = 8'h07;
    localparam logic [7:0] OFS_OPTIONS = 8'h08;
    localparam logic [7:0] OFS_PAUSE = 8'h09;
    localparam logic [7:0] OFS_EDGE = 8'h0a;
    localparam int CFG_COUNT = 5;

    typedef logic [REG_W-1:0] adcrb_byte_t;

    // Reset values
    localparam adcrb_byte_t RST_OPSTATE = 8'h42;
    localparam adcrb_byte_t RST_CFG_LOW = 8'hb6;
    localparam adcrb_byte_t RST_CFG_HIGH = 8'h08;
    localparam adcrb_byte_t RST_OPTIONS = 8'h00;
    localparam adcrb_byte_t RST_PAUSE = 8'h20;
    localparam adcrb_byte_t RST_EDGE = 8'h01;
    localparam adcrb_byte_t READ_ZERO = 8'h00;
    localparam adcrb_byte_t CFG_RESET [CFG_COUNT] = '{RST_CFG_LOW, RST_CFG_HIGH, RST_OPTIONS, RST_PAUSE, RST_EDGE};

    // Operating state register fields
    localparam int OS_START_BIT = 7;
    localparam int OS_PDOWN_BIT = 6;
    localparam int OS_STATE_MSB = 2;
    localparam int OS_STATE_LSB = 0;
    localparam logic [2:0] STATE_CFG = 3'h2;
    localparam logic [2:0] STATE_MEAS = 3'h3;

    // Configuration register fields
    localparam int CL_POL_BIT = 7;
    localparam int CL_GAIN_MSB = 6;
    localparam int CL_GAIN_LSB = 4;
    localparam int CH_MODE_MSB = 4;
    localparam int CH_MODE_LSB = 3;
    localparam logic [1:0] MODE_FREE_RUN = 2'h0;
    localparam logic [1:0] MODE_ON_REQUEST = 2'h1;

    // Serial slave address and framing
    localparam logic [4:0] I2C_ADDR_HI = 5'h1d;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_ACK_A = 3'b010,
        I2C_WRITE = 3'b011,
        I2C_ACK_W = 3'b100,
        I2C_READ = 3'b101,
        I2C_ACK_R = 3'b110
    } adcrb_i2c_state_t;
endpackage

/* File: include/adcrb_bank_if.sv */
// Internal carrier between the serial control logic and the register storage
`timescale 1ns/1ps
`default_nettype none
interface adcrb_bank_if;
    import adcrb_pkg::*;
    logic wr_stb;
    adcrb_byte_t wr_addr;
    adcrb_byte_t wr_data;
    adcrb_byte_t rd_addr;
    adcrb_byte_t rd_data;
    logic restore;

    modport ctrl (output wr_stb, output wr_addr, output wr_data, output rd_addr, output restore, input rd_data);
    modport bank (input wr_stb, input wr_addr, input wr_data, input rd_addr, input restore, output rd_data);
endinterface
`default_nettype wire

/* File: hdl/adcrb_store.sv */
// Configuration register storage, defaults restore and read decode
`timescale 1ns/1ps
`default_nettype none
module adcrb_store
    import adcrb_pkg::*;
#(
    parameter logic [3:0] PART_ID = 4'h9,  // Arbitrary value
    parameter logic [3:0] REVISION = 4'h3  // Arbitrary value
) (
    input wire logic clock_i,              // Converter clock
    input wire logic rst_i,                // Asynchronous reset, active high
    adcrb_bank_if.bank bus,                // Access from control logic
    output logic [REG_W-1:0] cfg_o [CFG_COUNT]  // Stored configuration bytes
);
    adcrb_byte_t regs [CFG_COUNT];

    // One byte register per configuration entry
    for (genvar i = 0; i < CFG_COUNT; i++) begin : g_reg
        localparam adcrb_byte_t MY_OFS = OFS_CFG_LOW + 8'(i);
        always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
                regs[i] <= CFG_RESET[i];
            end else if (bus.restore) begin
                regs[i] <= CFG_RESET[i];  // [RULE8] [RULE15]
            end else if (bus.wr_stb && bus.wr_addr == MY_OFS) begin
                regs[i] <= bus.wr_data;  // [RULE1] [RULE2]
            end
        end
        assign cfg_o[i] = regs[i];
    end

    // Read decode, write-only and unmapped bytes read zero
    always_comb begin
        bus.rd_data = READ_ZERO;  // [RULE3]
        if (bus.rd_addr == OFS_IFGEN) begin
            bus.rd_data = {PART_ID, REVISION};  // [RULE14]
        end
        for (int k = 0; k < CFG_COUNT; k++) begin
            if (bus.rd_addr == OFS_CFG_LOW + 8'(k)) begin
                bus.rd_data = regs[k];
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/adcrb_top.sv */
// Serial slave, operating state logic and register bank of the current-input converter
//
// Contract
// RULE1: every register holds eight bits
// RULE2: access is whole single bytes only
// RULE3: operating state register reads as zero
// RULE4: state register writable in any state
// RULE5: state code 010 configuration, 011 measurement
// RULE6: configuration state allows access, no measuring
// RULE7: measuring only in measurement state
// RULE8: leaving measurement restores configuration defaults
// RULE9: start bit one starts, zero stops
// RULE10: start bit honoured only measuring, two modes
// RULE11: power down bit acts in both states
// RULE12: power down only between conversions; code holds it off during a conversion only in measurement state
// RULE13: start, state and power down reset values
// RULE14: identification byte holds part and revision
// RULE15: polarity bit selects current direction, default one
// RULE16: gain field selects reference current
// RULE17: mode 00 free running, 01 on request
// RULE18: state register bit positions, reserved zero
// RULE19: measurement state ignores other register writes
`timescale 1ns/1ps
`default_nettype none
module adcrb_top
    import adcrb_pkg::*;
#(
    parameter logic [3:0] PART_ID = 4'h9,  // Arbitrary value
    parameter logic [3:0] REVISION = 4'h3  // Arbitrary value
) (
    input wire logic clock_i,                       // Converter clock, 200 MHz
    input wire logic rst_i,                         // Power-on reset, async, active high
    input wire logic scl_i,                         // Serial clock pin
    input wire logic sda_i,                         // Serial data pin level
    output logic sda_o,                             // Serial data drive value, always low
    output logic sda_oe_n_o,                        // Serial data enable, low drives
    input wire logic [1:0] addr_sel_i,              // Slave address strap pins
    input wire logic conv_busy_i,                   // Converter is inside a conversion
    output logic meas_state_o,                      // Measurement state active
    output logic measure_run_o,                     // Measurement started
    output logic measure_start_o,                   // Pulse on accepted start
    output logic power_down_o,                      // Power down request to analog
    output logic current_polarity_o,                // Input current direction
    output logic [2:0] gain_select_o,               // Reference current code
    output logic [1:0] meas_mode_o,                 // Measurement mode code
    output logic [REG_W-1:0] config_low_o,          // Low configuration byte
    output logic [REG_W-1:0] config_high_o,         // High configuration byte
    output logic [REG_W-1:0] options_o,             // Options byte
    output logic [REG_W-1:0] pause_length_o,        // Pause length byte
    output logic [REG_W-1:0] edge_select_o          // Edge select byte
);
    if (REG_W != 8) begin : g_bad_width
        $error("register width must be eight bits");
    end

    adcrb_bank_if bank_bus ();
    logic [REG_W-1:0] cfg [CFG_COUNT];

    adcrb_store #(
        .PART_ID(PART_ID),
        .REVISION(REVISION)
    ) u_store (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .bus(bank_bus),
        .cfg_o(cfg)
    );

    // Pin synchronisers and edge history
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic [1:0] sel_m, sel_s;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            sel_m <= 2'h0;
            sel_s <= 2'h0;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_d <= sda_s;
            sel_m <= addr_sel_i;
            sel_s <= sel_m;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    // Serial byte engine state
    adcrb_i2c_state_t i2c_st;
    logic [3:0] bit_cnt;
    adcrb_byte_t rx_shift;
    adcrb_byte_t tx_shift;
    adcrb_byte_t ptr;
    logic ptr_phase;
    logic rd_dir;
    logic wr_evt;
    adcrb_byte_t wr_addr;
    adcrb_byte_t wr_data;
    logic addr_match;
    assign addr_match = rx_shift[7:1] == {I2C_ADDR_HI, sel_s};

    // Serial protocol: address, pointer byte, then data bytes with auto increment
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            i2c_st <= I2C_IDLE;
            bit_cnt <= 4'h0;
            rx_shift <= READ_ZERO;
            tx_shift <= READ_ZERO;
            ptr <= OFS_OPSTATE;
            ptr_phase <= 1'b0;
            rd_dir <= 1'b0;
            sda_oe_n_o <= 1'b1;
            wr_evt <= 1'b0;
            wr_addr <= OFS_OPSTATE;
            wr_data <= READ_ZERO;
        end else begin
            wr_evt <= 1'b0;
            if (bus_start) begin
                i2c_st <= I2C_ADDR;
                bit_cnt <= 4'h0;
                sda_oe_n_o <= 1'b1;
            end else if (bus_stop) begin
                i2c_st <= I2C_IDLE;
                sda_oe_n_o <= 1'b1;
            end else begin
                case (i2c_st)
                    I2C_IDLE: begin
                        sda_oe_n_o <= 1'b1;
                    end
                    I2C_ADDR: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                            if (addr_match) begin
                                rd_dir <= rx_shift[0];
                                sda_oe_n_o <= 1'b0;
                                i2c_st <= I2C_ACK_A;
                            end else begin
                                i2c_st <= I2C_IDLE;
                            end
                        end
                    end
                    I2C_ACK_A: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (rd_dir) begin
                                sda_oe_n_o <= bank_bus.rd_data[REG_W-1];
                                tx_shift <= {bank_bus.rd_data[REG_W-2:0], 1'b0};
                                ptr <= ptr + 8'h01;
                                i2c_st <= I2C_READ;
                            end else begin
                                sda_oe_n_o <= 1'b1;
                                ptr_phase <= 1'b1;
                                i2c_st <= I2C_WRITE;
                            end
                        end
                    end
                    I2C_WRITE: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                            sda_oe_n_o <= 1'b0;
                            i2c_st <= I2C_ACK_W;
                            ptr_phase <= 1'b0;
                            if (ptr_phase) begin
                                ptr <= rx_shift;
                            end else begin
                                wr_evt <= 1'b1;  // [RULE2]
                                wr_addr <= ptr;
                                wr_data <= rx_shift;
                                ptr <= ptr + 8'h01;
                            end
                        end
                    end
                    I2C_ACK_W: begin
                        if (scl_fall) begin
                            sda_oe_n_o <= 1'b1;
                            bit_cnt <= 4'h0;
                            i2c_st <= I2C_WRITE;
                        end
                    end
                    I2C_READ: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == BYTE_BITS) begin
                                sda_oe_n_o <= 1'b1;
                                i2c_st <= I2C_ACK_R;
                            end else begin
                                sda_oe_n_o <= tx_shift[REG_W-1];
                                tx_shift <= {tx_shift[REG_W-2:0], 1'b0};
                            end
                        end
                    end
                    I2C_ACK_R: begin
                        if (scl_rise && sda_s) begin
                            i2c_st <= I2C_IDLE;  // Master refused more data
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            sda_oe_n_o <= bank_bus.rd_data[REG_W-1];
                            tx_shift <= {bank_bus.rd_data[REG_W-2:0], 1'b0};
                            ptr <= ptr + 8'h01;
                            i2c_st <= I2C_READ;
                        end
                    end
                    default: begin
                        i2c_st <= I2C_IDLE;
                        sda_oe_n_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Pin only ever pulls low
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // Operating state register decode
    logic opstate_wr;
    logic [2:0] new_state;
    logic mode_ok;
    assign opstate_wr = wr_evt && wr_addr == OFS_OPSTATE;  // [RULE4]
    assign new_state = wr_data[OS_STATE_MSB:OS_STATE_LSB];  // [RULE18]
    assign mode_ok = cfg[1][CH_MODE_MSB:CH_MODE_LSB] == MODE_FREE_RUN
        || cfg[1][CH_MODE_MSB:CH_MODE_LSB] == MODE_ON_REQUEST;  // [RULE17]

    logic pdown_req;
    logic next_meas;
    always_comb begin
        next_meas = meas_state_o;
        if (opstate_wr && new_state == STATE_MEAS) begin
            next_meas = 1'b1;  // [RULE5]
        end else if (opstate_wr && new_state == STATE_CFG) begin
            next_meas = 1'b0;  // [RULE5]
        end
    end

    // Operating state, start and power down bits
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meas_state_o <= RST_OPSTATE[OS_STATE_MSB:OS_STATE_LSB] == STATE_MEAS;  // [RULE13]
            measure_run_o <= RST_OPSTATE[OS_START_BIT];  // [RULE13]
            pdown_req <= RST_OPSTATE[OS_PDOWN_BIT];  // [RULE13]
            measure_start_o <= 1'b0;
            bank_bus.restore <= 1'b0;
        end else begin
            measure_start_o <= 1'b0;
            bank_bus.restore <= 1'b0;
            if (opstate_wr) begin
                meas_state_o <= next_meas;
                pdown_req <= wr_data[OS_PDOWN_BIT];  // [RULE11]
                if (!next_meas) begin
                    measure_run_o <= 1'b0;  // [RULE6] [RULE13]
                    bank_bus.restore <= meas_state_o;  // [RULE8]
                end else if (mode_ok) begin
                    measure_run_o <= wr_data[OS_START_BIT];  // [RULE9] [RULE10] [RULE7]
                    measure_start_o <= wr_data[OS_START_BIT];  // [RULE9]
                end
            end
        end
    end

    // Power down held off while a conversion runs in measurement state
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            power_down_o <= RST_OPSTATE[OS_PDOWN_BIT];
        end else begin
            power_down_o <= pdown_req && (!meas_state_o || !conv_busy_i);  // [RULE11] [RULE12]
        end
    end

    // Bank access, other registers frozen while measuring
    assign bank_bus.wr_stb = wr_evt && !meas_state_o && wr_addr != OFS_OPSTATE;  // [RULE19] [RULE6]
    assign bank_bus.wr_addr = wr_addr;
    assign bank_bus.wr_data = wr_data;
    assign bank_bus.rd_addr = ptr;

    // Configuration fields to the converter
    assign config_low_o = cfg[0];
    assign config_high_o = cfg[1];
    assign options_o = cfg[2];
    assign pause_length_o = cfg[3];
    assign edge_select_o = cfg[4];
    assign current_polarity_o = cfg[0][CL_POL_BIT];  // [RULE15]
    assign gain_select_o = cfg[0][CL_GAIN_MSB:CL_GAIN_LSB];  // [RULE16]
    assign meas_mode_o = cfg[1][CH_MODE_MSB:CH_MODE_LSB];
endmodule
`default_nettype wire

/* File: test/adcrb_top_sva.sv */
// Concurrent checks on the control register bank ports
`timescale 1ns/1ps
`default_nettype none
module adcrb_top_sva
    import adcrb_pkg::*;
(
    input wire logic clock_i,                  // Converter clock
    input wire logic rst_i,                    // Async reset
    input wire logic conv_busy_i,              // Conversion running
    input wire logic meas_state_o,             // Measurement state
    input wire logic measure_run_o,            // Run level
    input wire logic measure_start_o,          // Start pulse
    input wire logic power_down_o,             // Power down request
    input wire logic current_polarity_o,       // Current direction
    input wire logic [2:0] gain_select_o,      // Gain code
    input wire logic [1:0] meas_mode_o,        // Mode code
    input wire logic [REG_W-1:0] config_low_o,   // Low config byte
    input wire logic [REG_W-1:0] config_high_o,  // High config byte
    input wire logic [REG_W-1:0] options_o,      // Options byte
    input wire logic [REG_W-1:0] pause_length_o, // Pause byte
    input wire logic [REG_W-1:0] edge_select_o   // Edge byte
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Run and start only in measurement
    property p_run_in_meas;
        measure_run_o |-> meas_state_o;
    endproperty
    a_run_in_meas: assert property (p_run_in_meas) else $error("run outside measurement");
    property p_start_mode;
        measure_start_o |-> meas_state_o && meas_mode_o[1] == 1'b0;
    endproperty
    a_start_mode: assert property (p_start_mode) else $error("start in wrong mode");
    property p_start_pulse;
        measure_start_o |=> !measure_start_o;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    property p_run_rise;
        $rose(measure_run_o) |-> measure_start_o;
    endproperty
    a_run_rise: assert property (p_run_rise) else $error("run rose without start");
    // Power down held off during a conversion in measurement state
    property p_pdown_busy;
        $past(meas_state_o) && $past(conv_busy_i) |-> !power_down_o;
    endproperty
    a_pdown_busy: assert property (p_pdown_busy) else $error("power down during conversion");
    // Defaults back on leaving measurement
    property p_restore;
        $fell(meas_state_o) |-> ##[0:2] (config_low_o == RST_CFG_LOW && config_high_o == RST_CFG_HIGH
            && options_o == RST_OPTIONS && pause_length_o == RST_PAUSE && edge_select_o == RST_EDGE);
    endproperty
    a_restore: assert property (p_restore) else $error("defaults not restored");
    property p_frozen;
        meas_state_o && $past(meas_state_o) |-> $stable(config_low_o) && $stable(config_high_o)
            && $stable(options_o) && $stable(pause_length_o) && $stable(edge_select_o);
    endproperty
    a_frozen: assert property (p_frozen) else $error("config changed in measurement");
    // Field outputs follow their bytes
    property p_fields;
        current_polarity_o == config_low_o[7] && gain_select_o == config_low_o[6:4]
            && meas_mode_o == config_high_o[4:3];
    endproperty
    a_fields: assert property (p_fields) else $error("field outputs differ");
endmodule
`default_nettype wire

/* File: test/adcrb_host_model.sv */
// Behavioural serial host with open-drain data and idle-high clock
`timescale 1ns/1ps
`default_nettype none
module adcrb_host_model (
    output logic scl_o,       // Serial clock, still between frames
    output logic sda_oe_n_o,  // Low pulls data low
    input wire logic sda_i    // Resolved data level
);
    localparam time Q = 12;  // Quarter of the 48 ns bit period

    // Lines released at start
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    // Data moves only while the clock is low
    task automatic bit_out(input logic b);
        sda_oe_n_o = b;
        #Q scl_o = 1'b1;
        #(2*Q) scl_o = 1'b0;
        #Q;
    endtask
    task automatic bit_in(output logic b);
        sda_oe_n_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q b = sda_i;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    // Start or repeated start, and stop
    task automatic start();
        sda_oe_n_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_oe_n_o = 1'b0;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_oe_n_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_oe_n_o = 1'b1;
        #Q;
    endtask
    // Whole bytes only, most significant bit first
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(a);
        ack = ~a;
    endtask
    task automatic get_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(last);
    endtask
endmodule
`default_nettype wire

/* File: test/adc_control_register_bank_tb_top.sv */
// Self-checking bench for the converter control register bank
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_bank_tb_top;
    import adcrb_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic scl, host_oe_n, sda, dut_sda, dut_oe_n, meas, run, start, pdown, pol;
    logic [1:0] addr_sel = 2'h2;
    logic conv_busy = 1'b0;
    logic [2:0] gain;
    logic [1:0] mode;
    logic [7:0] cfg_lo, cfg_hi, opt, pause, edge_sel;
    int miscompares = 0;
    int checked = 0;

    // Wired-and data line with pull-up
    assign sda = host_oe_n & (dut_oe_n | dut_sda);

    adcrb_top #(.PART_ID(4'h5), .REVISION(4'ha)) i_adcrb_top (
        .clock_i(clock), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(dut_sda),
        .sda_oe_n_o(dut_oe_n), .addr_sel_i(addr_sel), .conv_busy_i(conv_busy),
        .meas_state_o(meas), .measure_run_o(run), .measure_start_o(start),
        .power_down_o(pdown), .current_polarity_o(pol), .gain_select_o(gain),
        .meas_mode_o(mode), .config_low_o(cfg_lo), .config_high_o(cfg_hi),
        .options_o(opt), .pause_length_o(pause), .edge_select_o(edge_sel)
    );
    adcrb_host_model i_adcrb_host_model (.scl_o(scl), .sda_oe_n_o(host_oe_n), .sda_i(sda));

    // Clock, reset and hang guard
    initial begin
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
    end
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        complete_run();
    end

    task automatic complete_run();
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Register write and read over the serial side
    task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
        logic a0, a1, a2;
        i_adcrb_host_model.start();
        i_adcrb_host_model.put_byte({I2C_ADDR_HI, addr_sel, 1'b0}, a0);
        i_adcrb_host_model.put_byte(ptr, a1);
        i_adcrb_host_model.put_byte(dat, a2);
        i_adcrb_host_model.stop();
        chk({5'h0, a0, a1, a2}, 8'h07);
        repeat (4) @(posedge clock);
    endtask
    task automatic rchk(input logic [7:0] ptr, input logic [7:0] exp);
        logic a0, a1, a2;
        logic [7:0] d;
        i_adcrb_host_model.start();
        i_adcrb_host_model.put_byte({I2C_ADDR_HI, addr_sel, 1'b0}, a0);
        i_adcrb_host_model.put_byte(ptr, a1);
        i_adcrb_host_model.start();
        i_adcrb_host_model.put_byte({I2C_ADDR_HI, addr_sel, 1'b1}, a2);
        i_adcrb_host_model.get_byte(d, 1'b1);
        i_adcrb_host_model.stop();
        chk({5'h0, a0, a1, a2}, 8'h07);
        chk(d, exp);
    endtask

    // Main sequence; reserved state bits always written as zero
    initial begin
        logic a;
        @(negedge rst);
        repeat (4) @(posedge clock);
        chk({5'h0, pdown, meas, run}, 8'h04);
        for (int i = 0; i < CFG_COUNT; i++) rchk(OFS_CFG_LOW + 8'(i), CFG_RESET[i]);
        rchk(OFS_OPSTATE, READ_ZERO);
        rchk(8'h01, 8'h00);
        wr(OFS_IFGEN, 8'hff);
        rchk(OFS_IFGEN, 8'h5a);
        wr(OFS_CFG_LOW, 8'h5a);
        chk({pol, gain, 4'h0}, 8'h50);
        rchk(OFS_CFG_LOW, 8'h5a);
        for (int g = 0; g < 3; g++) begin
            wr(OFS_CFG_LOW, {1'b1, 3'(g), 4'h6});
            chk({5'h0, gain}, 8'(g));
        end
        // Other slave address left unanswered
        i_adcrb_host_model.start();
        i_adcrb_host_model.put_byte({I2C_ADDR_HI, ~addr_sel, 1'b0}, a);
        i_adcrb_host_model.stop();
        chk({7'h0, a}, 8'h00);
        wr(OFS_OPSTATE, 8'h82);
        chk({6'h0, meas, run}, 8'h00);
        // Every mode code with a start request
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CFG_HIGH, {3'h0, 2'(m), 3'h0});
            chk({6'h0, mode}, 8'(m));
            wr(OFS_OPSTATE, 8'h83);
            chk({5'h0, pdown, meas, run}, (m < 2) ? 8'h03 : 8'h02);
            wr(OFS_OPSTATE, 8'h02);
            chk(cfg_hi, RST_CFG_HIGH);
        end
        // Measurement: frozen bank, power down between conversions
        wr(OFS_CFG_LOW, 8'h00);
        wr(OFS_OPSTATE, 8'h83);
        wr(OFS_CFG_LOW, 8'h11);
        chk(cfg_lo, 8'h00);
        @(posedge clock) conv_busy <= 1'b1;
        wr(OFS_OPSTATE, 8'h43);
        chk({5'h0, pdown, meas, run}, 8'h02);
        @(posedge clock) conv_busy <= 1'b0;
        repeat (3) @(posedge clock);
        chk({5'h0, pdown, meas, run}, 8'h06);
        wr(OFS_OPSTATE, 8'hc4);
        chk({5'h0, pdown, meas, run}, 8'h07);
        wr(OFS_OPSTATE, 8'h02);
        chk(cfg_lo, RST_CFG_LOW);
        chk({5'h0, pdown, meas, run}, 8'h00);
        wr(OFS_OPSTATE, 8'h42);
        chk({5'h0, pdown, meas, run}, 8'h04);
        complete_run();
    end
endmodule

bind adcrb_top adcrb_top_sva i_adcrb_top_sva (
    .clock_i, .rst_i, .conv_busy_i, .meas_state_o, .measure_run_o, .measure_start_o,
    .power_down_o, .current_polarity_o, .gain_select_o, .meas_mode_o, .config_low_o,
    .config_high_o, .options_o, .pause_length_o, .edge_select_o
);
`default_nettype wire
